/* File: logic/cdt_timer.sv */
// countdown timer with reload, sticky flag and interrupt pin drive
// assumes control inputs are synchronous levels, writes and clears are pulses
`timescale 1ns/1ps

// Summary of operation
// - source select picks 4096, 64, 1, 1/60 Hz
// - 8-bit counter decrements once per source tick
// - zero reload value stops the countdown
// - at one: set flag, reload, continue
// - count readback shows the live counter
// - new reload value takes effect immediately
// - stored value reloads intact every later period
// - first period may last n-1 to n
// - flag stays set until software clears it
// - pulse mode bit selects pulse or level
// - disabled interrupt keeps pin idle, flag still sets
// - 1 Hz and minute periods include trim pulses
// - pulse width depends on source and n
// - flag and interrupt assert in same cycle
// - mode bit 0 gives level following flag
// - interrupt enable resets to zero
module cdt_timer #(
    parameter int TICK_CYCLES = cdt_pkg::TICK8K_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control levels
    input wire logic [1:0] source_select,
    input wire logic count_enable,
    input wire logic timer_irq_enable,
    input wire logic irq_pulse_mode,
    // value write and flag clear
    input wire logic value_wr,
    input wire logic [7:0] value_wdata,
    input wire logic flag_clr,
    // offset trim pulses
    input wire logic trim_add,
    input wire logic trim_drop,
    // status
    output logic [7:0] count_value,
    output logic [7:0] reload_value,
    output logic countdown_flag,
    // open-drain interrupt pin, active low
    output logic irq_n_out,
    output logic irq_n_oe
);
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] reload;
        logic flag;
        logic [7:0] pulse_cnt;
        logic irq;
    } cdt_timer_s;

    cdt_timer_s st;
    cdt_timer_s next_st;
    logic src_tick;
    logic expire;
    logic [7:0] width;

    cdt_tick_if ticks ();

    // ****************************************
    // source clock enables
    // ****************************************
    cdt_prescaler #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_pre (
        .clk(clk),
        .reset_n(reset_n),
        .trim_add(trim_add),
        .trim_drop(trim_drop),
        .ticks(ticks.src)
    );

    // ****************************************
    // countdown, flag and interrupt
    // ****************************************
    always_comb begin
        next_st = st;
        // pick the source tick
        case (source_select)
            cdt_pkg::SRC_4K: src_tick = ticks.tick_4k;
            cdt_pkg::SRC_64: src_tick = ticks.tick_64;
            cdt_pkg::SRC_1HZ: src_tick = ticks.tick_1hz;
            cdt_pkg::SRC_MIN: src_tick = ticks.tick_min;
            default: src_tick = 1'b0;
        endcase
        // pulse width per source and loaded value
        case (source_select)
            cdt_pkg::SRC_4K: width = (st.reload == cdt_pkg::COUNT_ONE) ?
                cdt_pkg::PW_4K_ONE : cdt_pkg::PW_4K;
            cdt_pkg::SRC_64: width = (st.reload == cdt_pkg::COUNT_ONE) ?
                cdt_pkg::PW_64_ONE : cdt_pkg::PW_LONG;
            default: width = cdt_pkg::PW_LONG;
        endcase
        // free-running source gives first period n-1 to n
        expire = 1'b0;
        if (value_wr) begin
            next_st.reload = value_wdata;
            next_st.count = value_wdata;
        end else if (count_enable && src_tick && st.count != cdt_pkg::COUNT_RESET) begin
            if (st.count == cdt_pkg::COUNT_ONE) begin
                expire = 1'b1;
                next_st.count = st.reload;
            end else begin
                next_st.count = st.count - 1'b1;
            end
        end
        // sticky flag, set wins over clear
        if (expire) begin
            next_st.flag = 1'b1;
        end else if (flag_clr) begin
            next_st.flag = 1'b0;
        end
        // pulse length counter in 8192 Hz ticks
        if (expire) begin
            next_st.pulse_cnt = width;
        end else if (ticks.tick_8k && st.pulse_cnt != '0) begin
            next_st.pulse_cnt = st.pulse_cnt - 1'b1;
        end
        // pin follows next state so flag and pin rise together
        if (!timer_irq_enable) begin
            next_st.irq = 1'b0;
        end else if (irq_pulse_mode) begin
            next_st.irq = (next_st.pulse_cnt != '0);
        end else begin
            next_st.irq = next_st.flag;
        end
    end

    // state register, enable bits are inputs reset by their owner
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign count_value = st.count;
    assign reload_value = st.reload;
    assign countdown_flag = st.flag;
    assign irq_n_out = 1'b0 & st.irq;
    assign irq_n_oe = st.irq;
endmodule

/* File: logic/cdt_pkg.sv */
// constants shared by the countdown timer and its prescaler
// assumes a single 100 MHz clock and active-low asynchronous reset
package cdt_pkg;
    // ****************************************
    // clock and time base
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    // base tick of 8192 Hz, period 1/8192 s rounded down to whole ns
    localparam int TICK8K_PERIOD_NS = 122070;
    localparam int TICK8K_CYCLES = TICK8K_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_CNT_W = 14;

    // ****************************************
    // source derivation from the 8192 Hz base
    // ****************************************
    localparam int SEC_CNT_W = 13;               // 8192 base ticks per second
    localparam logic [6:0] DIV64_LAST = 7'h7f;   // 128 base ticks per 64 Hz tick
    localparam logic [5:0] MIN_LAST = 6'h3b;     // 60 seconds per minute tick
    localparam logic [SEC_CNT_W:0] STEP_NORMAL = 14'h0001;
    localparam logic [SEC_CNT_W:0] STEP_ADD = 14'h0002;
    localparam logic [SEC_CNT_W:0] STEP_DROP = 14'h0000;

    // ****************************************
    // source select codes
    // ****************************************
    localparam logic [1:0] SRC_4K = 2'h0;
    localparam logic [1:0] SRC_64 = 2'h1;
    localparam logic [1:0] SRC_1HZ = 2'h2;
    localparam logic [1:0] SRC_MIN = 2'h3;

    // ****************************************
    // interrupt pulse widths in 8192 Hz ticks
    // ****************************************
    localparam logic [7:0] PW_4K_ONE = 8'h01;    // 1/8192 s
    localparam logic [7:0] PW_4K = 8'h02;        // 1/4096 s
    localparam logic [7:0] PW_64_ONE = 8'h40;    // 1/128 s
    localparam logic [7:0] PW_LONG = 8'h80;      // 1/64 s

    // ****************************************
    // reset and expiry count values
    // ****************************************
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_ONE = 8'h01;
endpackage

/* File: logic/cdt_tick_if.sv */
// source clock enables passed from the prescaler to the timer
// assumes every tick is a one-cycle pulse on the system clock
`timescale 1ns/1ps
interface cdt_tick_if;
    logic tick_8k;
    logic tick_4k;
    logic tick_64;
    logic tick_1hz;
    logic tick_min;
    modport src (output tick_8k, output tick_4k, output tick_64, output tick_1hz,
                 output tick_min);
    modport dst (input tick_8k, input tick_4k, input tick_64, input tick_1hz,
                 input tick_min);
endinterface

/* File: logic/cdt_prescaler.sv */
// prescaler: free-running source enables for the countdown timer
// assumes trim inputs are one-cycle pulses from the offset trim logic
`timescale 1ns/1ps
module cdt_prescaler #(
    parameter int TICK_CYCLES = cdt_pkg::TICK8K_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // offset trim requests
    input wire logic trim_add,
    input wire logic trim_drop,
    // source enables
    cdt_tick_if.src ticks
);
    typedef struct packed {
        logic [cdt_pkg::TICK_CNT_W-1:0] clk_cnt;
        logic [6:0] div64;
        logic [cdt_pkg::SEC_CNT_W-1:0] sec_cnt;
        logic [5:0] min_cnt;
        logic half;
        logic t8k;
        logic t4k;
        logic t64;
        logic t1hz;
        logic tmin;
    } cdt_pre_s;

    localparam logic [cdt_pkg::TICK_CNT_W-1:0] LAST =
        cdt_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

    cdt_pre_s st;
    cdt_pre_s next_st;
    logic base;
    logic [cdt_pkg::SEC_CNT_W:0] sec_sum;

    // ****************************************
    // divider chain
    // ****************************************
    always_comb begin
        next_st = st;
        base = (st.clk_cnt == LAST);
        next_st.clk_cnt = base ? '0 : st.clk_cnt + 1'b1;
        // seconds path carries correction pulses
        if (trim_add) begin
            sec_sum = {1'b0, st.sec_cnt} + cdt_pkg::STEP_ADD;
        end else if (trim_drop) begin
            sec_sum = {1'b0, st.sec_cnt} + cdt_pkg::STEP_DROP;
        end else begin
            sec_sum = {1'b0, st.sec_cnt} + cdt_pkg::STEP_NORMAL;
        end
        next_st.t8k = base;
        next_st.t4k = base & st.half;
        next_st.t64 = base & (st.div64 == cdt_pkg::DIV64_LAST);
        next_st.t1hz = base & sec_sum[cdt_pkg::SEC_CNT_W];
        next_st.tmin = next_st.t1hz & (st.min_cnt == cdt_pkg::MIN_LAST);
        if (base) begin
            next_st.half = ~st.half;
            next_st.div64 = st.div64 + 1'b1;
            next_st.sec_cnt = sec_sum[cdt_pkg::SEC_CNT_W-1:0];
            if (next_st.t1hz) begin
                next_st.min_cnt = next_st.tmin ? '0 : st.min_cnt + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ticks.tick_8k = st.t8k;
    assign ticks.tick_4k = st.t4k;
    assign ticks.tick_64 = st.t64;
    assign ticks.tick_1hz = st.t1hz;
    assign ticks.tick_min = st.tmin;
endmodule

/* File: sim/cdt_timer_props.sv */
// checker for the countdown timer, bound to its top module
// assumes one clock domain and active-low asynchronous reset
`timescale 1ns/1ps
module cdt_timer_props #(
    parameter int TICK_CYCLES = cdt_pkg::TICK8K_CYCLES
) (
    // watched ports, grouped to keep the file short
    input wire logic clk, input wire logic reset_n,
    input wire logic [1:0] source_select, input wire logic count_enable,
    input wire logic timer_irq_enable, input wire logic irq_pulse_mode,
    input wire logic value_wr, input wire logic [7:0] value_wdata,
    input wire logic flag_clr, input wire logic trim_add, input wire logic trim_drop,
    input wire logic [7:0] count_value, input wire logic [7:0] reload_value,
    input wire logic countdown_flag, input wire logic irq_n_out, input wire logic irq_n_oe
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_WR_LOAD: assert property (value_wr |=> count_value == $past(value_wdata)
        && reload_value == $past(value_wdata)) else $error("write not loaded");
    AST_STEP: assert property (!$past(value_wr) && count_value != $past(count_value)
        |-> count_value == $past(count_value) - 8'h01 || ($past(count_value) == 8'h01
        && count_value == reload_value && countdown_flag)) else $error("bad count step");
    AST_ZERO_STOP: assert property (count_value == 8'h00 && !value_wr
        |=> count_value == 8'h00 && !$rose(countdown_flag)) else $error("zero count moved");
    AST_HOLD: assert property (!count_enable && !value_wr
        |=> $stable(count_value) && !$rose(countdown_flag)) else $error("disabled count moved");
    AST_FLAG_SET: assert property ($rose(countdown_flag)
        |-> $past(count_value) == 8'h01 && $past(count_enable)) else $error("flag set early");
    AST_STICKY: assert property (countdown_flag && !flag_clr |=> countdown_flag)
        else $error("flag lost");
    AST_CLR: assert property (flag_clr && count_value != 8'h01 |=> !countdown_flag)
        else $error("flag not cleared");
    AST_SAME: assert property ($rose(countdown_flag) && $past(timer_irq_enable)
        |-> irq_n_oe && irq_n_out == 1'b0) else $error("pin late");
    AST_LEVEL: assert property (!irq_pulse_mode && $stable(irq_pulse_mode)
        && $stable(timer_irq_enable) |-> irq_n_oe == (countdown_flag && timer_irq_enable))
        else $error("level pin wrong");
    AST_IRQ_OFF: assert property (!timer_irq_enable && !$past(timer_irq_enable)
        |-> !irq_n_oe) else $error("pin driven while off");
endmodule
bind cdt_timer cdt_timer_props #(.TICK_CYCLES(TICK_CYCLES)) cdt_timer_props_inst (
    .clk(clk), .reset_n(reset_n), .source_select(source_select),
    .count_enable(count_enable), .timer_irq_enable(timer_irq_enable),
    .irq_pulse_mode(irq_pulse_mode), .value_wr(value_wr), .value_wdata(value_wdata),
    .flag_clr(flag_clr), .trim_add(trim_add), .trim_drop(trim_drop),
    .count_value(count_value), .reload_value(reload_value),
    .countdown_flag(countdown_flag), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

/* File: sim/cdt_timer_tb.sv */
// testbench for the countdown timer with a shortened base tick
// assumes the checker is bound to the timer; trim inputs pulsed in the 1 Hz run
`timescale 1ns/1ps
module cdt_timer_tb;
    localparam int T = 4;
    logic clk = 0;
    logic reset_n = 0;
    logic count_enable = 0;
    logic timer_irq_enable = 0;
    logic irq_pulse_mode = 0;
    logic value_wr = 0;
    logic flag_clr = 0;
    logic [1:0] source_select = 2'h3;
    logic [7:0] value_wdata = 8'h00;
    logic trim_add = 0;
    logic trim_drop = 0;
    logic [7:0] count_value, reload_value;
    logic countdown_flag, irq_n_out, irq_n_oe;
    logic fl_q = 0;
    logic oe_q = 0;
    logic [31:0] seed = 32'haf00854d;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    int w = 0;
    int pw_e = 0;
    logic [7:0] q_cnt[$];
    int q_w[$];
    // ****
    // clock, design and helpers
    // ****
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    cdt_timer #(.TICK_CYCLES(T)) cdt_timer_inst (.clk(clk), .reset_n(reset_n),
        .source_select(source_select), .count_enable(count_enable),
        .timer_irq_enable(timer_irq_enable), .irq_pulse_mode(irq_pulse_mode),
        .value_wr(value_wr), .value_wdata(value_wdata), .flag_clr(flag_clr),
        .trim_add(trim_add), .trim_drop(trim_drop), .count_value(count_value),
        .reload_value(reload_value), .countdown_flag(countdown_flag),
        .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task summarize;
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // compare tasks, one per kind of result
    task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_cyc(input string nm, input int e, input int g);
        n_tests++;
        if (g != e) begin
            miscompares++;
            $display("Error %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    // drive just after the rising edge
    task step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task wr(input logic [7:0] v);
        value_wdata = v;
        value_wr = 1;
        step(1);
        value_wr = 0;
    endtask
    task clr;
        flag_clr = 1;
        step(1);
        flag_clr = 0;
    endtask
    task wait_fl;
        int k;
        k = 0;
        while (countdown_flag !== 1'b1 && k < 70000) begin
            step(1);
            k++;
        end
        if (k == 70000) begin
            miscompares++;
            summarize();
        end
    endtask
    // one source: two expiries, second period timed exactly
    task run(input logic [1:0] s, input logic [7:0] n, input logic pm, input logic ie,
             input int div, input int pw);
        int t0;
        int adj;
        adj = 0;
        source_select = s;
        irq_pulse_mode = pm;
        timer_irq_enable = ie;
        repeat (2) q_cnt.push_back(n);
        if (pm)
            repeat (2) q_w.push_back(pw);
        wr(n);
        count_enable = 1;
        wait_fl();
        t0 = cyc;
        clr();
        // one doubled step and two skipped steps: one base tick longer
        if (s == cdt_pkg::SRC_1HZ) begin
            trim_add = 1;
            step(T);
            trim_add = 0;
            trim_drop = 1;
            step(2 * T);
            trim_drop = 0;
            adj = T;
        end
        wait_fl();
        chk_cyc("period", n * div * T + adj, cyc - t0);
        count_enable = 0;
        clr();
        step(600);
    endtask
    // ****
    // monitor of flag events and pin pulses
    // ****
    always @(negedge clk) begin
        if (countdown_flag === 1'b1 && fl_q !== 1'b1) begin
            if (q_cnt.size() == 0)
                chk_bit("flag_event", 1'b0, 1'b1);
            else
                chk_val("count_reload", q_cnt.pop_front(), count_value);
            chk_bit("irq_with_flag", timer_irq_enable, irq_n_oe);
            if (timer_irq_enable === 1'b1)
                chk_bit("irq_pin_low", 1'b0, irq_n_out);
        end
        if (irq_n_oe === 1'b1)
            w = w + 1;
        else begin
            // ticks share the base phase, so a pulse is whole base ticks long
            if (oe_q === 1'b1 && irq_pulse_mode === 1'b1 && q_w.size() > 0) begin
                pw_e = q_w.pop_front();
                chk_cyc("pulse_width", pw_e * T, w);
            end
            w = 0;
        end
        fl_q <= countdown_flag;
        oe_q <= irq_n_oe;
    end
    // ****
    // main sequence
    // ****
    initial begin
        step(5);
        reset_n = 1;
        chk_bit("reset_oe", 1'b0, irq_n_oe);
        chk_bit("reset_flag", 1'b0, countdown_flag);
        source_select = cdt_pkg::SRC_4K;
        count_enable = 1;
        wr(8'h00);
        step(100);
        chk_val("zero_count", 8'h00, count_value);
        count_enable = 0;
        seed = lfsr(seed);
        run(cdt_pkg::SRC_4K, 8'h01, 1, 1, 2, cdt_pkg::PW_4K_ONE);
        run(cdt_pkg::SRC_4K, 8'h02 + seed[1:0], 1, 1, 2, cdt_pkg::PW_4K);
        run(cdt_pkg::SRC_64, 8'h01, 1, 1, 128, cdt_pkg::PW_64_ONE);
        run(cdt_pkg::SRC_64, 8'h02, 0, 0, 128, 0);
        run(cdt_pkg::SRC_1HZ, 8'h01, 0, 1, 8192, 0);
        // held on a fast source, then three 4096 Hz ticks, then held for a reread
        source_select = cdt_pkg::SRC_4K;
        wr(8'h09);
        step(50);
        chk_val("hold_count", 8'h09, count_value);
        count_enable = 1;
        step(3 * 2 * T);
        chk_val("live_count", 8'h06, count_value);
        count_enable = 0;
        step(1);
        chk_val("reread_count", 8'h06, count_value);
        chk_val("reload_kept", 8'h09, reload_value);
        source_select = cdt_pkg::SRC_MIN;
        summarize();
    end
endmodule
